// ===== hdl/hsfr_core.v
// Hot-swap fault timer, retry sequencer, gate control and status registers.
`timescale 1ns/1ns
`include "hsfr_map.vh"
module hsfr_core (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        undervoltage_enable_input,
  input  wire        overvoltage_input,
  input  wire        good_sense_input,
  input  wire        power_limit_set_input,
  input  wire        current_limit_input,
  input  wire        retry_select_input,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output reg         gate_drive,
  output reg         output_good_flag,
  output wire        alert_n
);
  ////////////////////////////////////////////////////////////////////////////
  localparam ST_INSERT  = 3'h0;
  localparam ST_WAIT    = 3'h1;
  localparam ST_ON      = 3'h2;
  localparam ST_LATCHED = 3'h3;
  localparam ST_RISE    = 3'h4;
  localparam ST_FALL    = 3'h5;
  localparam ST_LAST    = 3'h6;

  wire [3:0]  pins_s;
  wire        uv_ok     = pins_s[0];
  wire        ov_high   = pins_s[1];
  wire        good_s    = pins_s[2];
  wire        retry_pin = pins_s[3];
  wire [1:0]  lim_s;
  wire        limiting  = lim_s[0] | lim_s[1];

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [2:0]  cyc_reg;
  reg  [4:0]  tries_reg;
  reg  [7:0]  in_stat_reg;
  reg  [15:0] fsum_reg;
  reg  [15:0] mask_reg;
  reg  [7:0]  setup_reg;
  reg         preset_reg;
  reg         uv_seen_reg;
  reg         charge;
  reg         dis_fast;
  reg         dis_slow;
  reg         tclr;
  reg  [15:0] up_step;
  wire [15:0] tcount;
  wire        at_trip;
  wire        at_low;
  wire        at_restart;
  wire        clear_cmd = reg_wr && (reg_addr == `HSFR_OFS_CLEAR);

  hsfr_sync #(.W(4)) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .pin_in   ({retry_select_input, good_sense_input, overvoltage_input,
                undervoltage_enable_input}),
    .pin_sync (pins_s)
  );

  hsfr_sync #(.W(2)) u_sync_lim (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .pin_in   ({power_limit_set_input, current_limit_input}),
    .pin_sync (lim_s)
  );

  hsfr_timer u_timer (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .charge     (charge),
    .dis_fast   (dis_fast),
    .dis_slow   (dis_slow),
    .clr        (tclr),
    .up_step    (up_step),
    .count      (tcount),
    .at_trip    (at_trip),
    .at_low     (at_low),
    .at_restart (at_restart)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Retry budget: endless is 5'h1F, otherwise the count of restarts allowed.
  function [4:0] retry_budget;
    input [2:0] sel;
    input       pin;
    begin
      case (sel)
        `HSFR_RT_ZERO:    retry_budget = 5'h00;
        `HSFR_RT_ONE:     retry_budget = 5'h01;
        `HSFR_RT_TWO:     retry_budget = 5'h02;
        `HSFR_RT_FOUR:    retry_budget = 5'h04;
        `HSFR_RT_EIGHT:   retry_budget = 5'h08;
        `HSFR_RT_SIXTEEN: retry_budget = 5'h10;
        `HSFR_RT_ENDLESS: retry_budget = 5'h1F;
        default:          retry_budget = pin ? 5'h00 : 5'h1F;
      endcase
    end
  endfunction

  wire [4:0] budget  = retry_budget(setup_reg[`HSFR_SETUP_RT_HI:`HSFR_SETUP_RT_LO],
                                    retry_pin);
  wire       endless = (budget == 5'h1F);
  wire       may_try = endless || (tries_reg < budget);
  wire       gate_ok = uv_ok && !ov_high;
  wire       trip    = (state_reg == ST_ON) && limiting && at_trip;

  ////////////////////////////////////////////////////////////////////////////
  always @* begin
    state_next = state_reg;
    charge     = 1'b0;
    dis_fast   = 1'b0;
    dis_slow   = 1'b0;
    tclr       = 1'b0;
    up_step    = `HSFR_STEP_FAULT;
    case (state_reg)
      ST_INSERT: begin
        charge  = 1'b1;
        up_step = `HSFR_STEP_INSERT;
        if (at_trip) begin
          tclr       = 1'b1;
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        dis_fast = 1'b1;
        if (gate_ok) begin
          state_next = ST_ON;
        end
      end
      ST_ON: begin
        if (!gate_ok) begin
          state_next = ST_WAIT;
        end else if (limiting) begin
          charge = 1'b1;
          if (at_trip) begin
            state_next = may_try ? ST_RISE : ST_LATCHED;
          end
        end else begin
          dis_fast = 1'b1;
        end
      end
      ST_LATCHED: begin
        dis_slow = 1'b1;
        if (!uv_ok && at_restart) begin
          state_next = ST_WAIT;
        end
      end
      ST_RISE: begin
        charge = 1'b1;
        if (at_trip) begin
          state_next = (cyc_reg == `HSFR_CYCLES) ? ST_LAST : ST_FALL;
        end
      end
      ST_FALL: begin
        dis_slow = 1'b1;
        if (at_low) begin
          state_next = ST_RISE;
        end
      end
      ST_LAST: begin
        dis_slow = 1'b1;
        if (at_restart) begin
          state_next = ST_WAIT;
        end
      end
      default: state_next = ST_INSERT;
    endcase
  end

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg  <= ST_INSERT;
      cyc_reg    <= 3'h0;
      tries_reg  <= 5'h00;
      gate_drive <= 1'b0;
    end else begin
      state_reg  <= state_next;
      gate_drive <= (state_next == ST_ON);
      // Seven full falls to the low level are counted before the final fall.
      if (state_reg == ST_ON && state_next == ST_RISE) begin
        cyc_reg <= 3'h0;
        if (!endless) begin
          tries_reg <= tries_reg + 5'h01;
        end
      end else if (state_reg == ST_FALL && state_next == ST_RISE) begin
        cyc_reg <= cyc_reg + 3'h1;
      end
      if (!uv_ok) begin
        tries_reg <= 5'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status; a new event in the clear cycle wins over the clear.
  wire ev_over = trip;
  wire ev_uv   = uv_seen_reg && !uv_ok;
  wire ev_ov   = ov_high;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      in_stat_reg      <= 8'h00;
      fsum_reg         <= 16'h0000;
      mask_reg         <= 16'h0000;
      setup_reg        <= 8'h00;
      preset_reg       <= 1'b1;
      uv_seen_reg      <= 1'b0;
      output_good_flag <= 1'b0;
    end else begin
      if (uv_ok) begin
        uv_seen_reg <= 1'b1;
      end
      output_good_flag <= good_s;
      if (reg_wr && reg_addr == `HSFR_OFS_MASK) begin
        mask_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `HSFR_OFS_SETUP) begin
        setup_reg <= reg_wdata[7:0];
      end
      if (clear_cmd) begin
        in_stat_reg <= 8'h00;
        fsum_reg    <= 16'h0000;
        preset_reg  <= 1'b0;
      end
      if (ev_over) begin
        in_stat_reg[`HSFR_IN_OVERLOAD] <= 1'b1;
        fsum_reg[`HSFR_FS_OVERLOAD]    <= 1'b1;
      end
      if (ev_uv) begin
        in_stat_reg[`HSFR_IN_UV] <= 1'b1;
        fsum_reg[`HSFR_FS_UV]    <= 1'b1;
      end
      if (ev_ov) begin
        in_stat_reg[`HSFR_IN_OV] <= 1'b1;
        fsum_reg[`HSFR_FS_OV]    <= 1'b1;
      end
    end
  end

  wire latched = (state_reg == ST_LATCHED);
  wire [15:0] fsum_view = fsum_reg | ({15'h0000, latched} << `HSFR_FS_LATCHED)
                        | ({15'h0000, output_good_flag} << `HSFR_FS_GOOD);
  wire [15:0] sw_view = ({15'h0000, !output_good_flag} << `HSFR_SW_NOT_GOOD)
                      | ({15'h0000, |in_stat_reg} << `HSFR_SW_INPUT);
  wire [15:0] alert_src = fsum_reg & ~mask_reg;
  assign alert_n = !((|alert_src) || preset_reg);

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `HSFR_OFS_SUMMARY:  reg_rdata <= sw_view;
        `HSFR_OFS_INPUT:    reg_rdata <= {8'h00, in_stat_reg};
        `HSFR_OFS_MASK:     reg_rdata <= mask_reg;
        `HSFR_OFS_SETUP:    reg_rdata <= {8'h00, setup_reg};
        `HSFR_OFS_FAULTSUM: reg_rdata <= fsum_view;
        `HSFR_OFS_MFR:      reg_rdata <= {11'h000, preset_reg, 4'h0};
        default:            reg_rdata <= 16'h0000;
      endcase
    end
  end
endmodule // hsfr_core

// ===== hdl/hsfr_map.vh
// Register offsets, field positions and timer constants of the hot-swap sequencer.
`ifndef HSFR_MAP_VH
`define HSFR_MAP_VH
`define HSFR_OFS_SUMMARY  8'h79
`define HSFR_OFS_INPUT    8'h7C
`define HSFR_OFS_MASK     8'hD8
`define HSFR_OFS_SETUP    8'hD9
`define HSFR_OFS_FAULTSUM 8'hE1
`define HSFR_OFS_MFR      8'h80
`define HSFR_OFS_CLEAR    8'h03
// Input status bits.
`define HSFR_IN_OV        4
`define HSFR_IN_UV        3
`define HSFR_IN_OVERLOAD  1
// Fault summary bits.
`define HSFR_FS_OVERLOAD  11
`define HSFR_FS_UV        10
`define HSFR_FS_OV        9
`define HSFR_FS_LATCHED   7
`define HSFR_FS_GOOD      3
// Summary status bits that show power good is low and that any input status bit is set.
`define HSFR_SW_NOT_GOOD  11
`define HSFR_SW_INPUT     13
// Preset flag in the manufacturer status byte.
`define HSFR_MFR_PRESET   4
// Setup register retry field.
`define HSFR_SETUP_RT_HI  7
`define HSFR_SETUP_RT_LO  5
`define HSFR_RT_PIN       3'h0
`define HSFR_RT_ZERO      3'h1
`define HSFR_RT_ONE       3'h2
`define HSFR_RT_TWO       3'h3
`define HSFR_RT_FOUR      3'h4
`define HSFR_RT_EIGHT     3'h5
`define HSFR_RT_SIXTEEN   3'h6
`define HSFR_RT_ENDLESS   3'h7
// Timer levels, counter of 16 bits with 1.7 V at full scale trip.
`define HSFR_LVL_TRIP     16'hFF00
`define HSFR_LVL_LOW      16'h9600
`define HSFR_LVL_RESTART  16'h2D00
`define HSFR_STEP_FAULT   16'h0100
`define HSFR_STEP_FAST    16'h0400
`define HSFR_STEP_SLOW    16'h0008
`define HSFR_STEP_INSERT  16'h0010
`define HSFR_CYCLES       3'h7
`endif

// ===== hdl/hsfr_sync.v
// Two flip-flop synchroniser for a group of pin levels.
`timescale 1ns/1ns
module hsfr_sync #(
  parameter W = 4
) (
  input  wire         clk_sys,
  input  wire         resetn,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_sync
);
  reg [W-1:0] meta_reg;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= {W{1'b0}};
      pin_sync <= {W{1'b0}};
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end
endmodule // hsfr_sync

// ===== hdl/hsfr_timer.v
// Fault timer counter with charge and discharge steps and level compares.
`timescale 1ns/1ns
`include "hsfr_map.vh"
module hsfr_timer (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        charge,
  input  wire        dis_fast,
  input  wire        dis_slow,
  input  wire        clr,
  input  wire [15:0] up_step,
  output reg  [15:0] count,
  output wire        at_trip,
  output wire        at_low,
  output wire        at_restart
);
  wire [16:0] sum  = {1'b0, count} + {1'b0, up_step};
  wire [15:0] down = dis_fast ? `HSFR_STEP_FAST : `HSFR_STEP_SLOW;
  assign at_trip    = count >= `HSFR_LVL_TRIP;
  assign at_low     = count <= `HSFR_LVL_LOW;
  assign at_restart = count <= `HSFR_LVL_RESTART;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count <= 16'h0000;
    end else if (clr) begin
      count <= 16'h0000;
    end else if (charge) begin
      count <= sum[16] ? 16'hFFFF : sum[15:0];
    end else if (dis_fast || dis_slow) begin
      count <= (count > down) ? count - down : 16'h0000;
    end
  end
endmodule // hsfr_timer

// ===== verif/hsfr_core_props.sv
// Port-level checks on the hot-swap sequencer core.
`timescale 1ns/1ns
module hsfr_core_props (
  input wire        clk_sys,
  input wire        resetn,
  input wire        undervoltage_enable_input,
  input wire        overvoltage_input,
  input wire        good_sense_input,
  input wire        power_limit_set_input,
  input wire        current_limit_input,
  input wire        retry_select_input,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire        gate_drive,
  input wire        output_good_flag,
  input wire        alert_n
);
  reg  [8:0] lim_cnt_reg;
  wire [8:0] lim_cnt_next;
  // Counts cycles of limiting while the pass transistor is driven on.
  assign lim_cnt_next = (gate_drive && (power_limit_set_input || current_limit_input)) ?
                        lim_cnt_reg + 9'h001 : 9'h000;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      lim_cnt_reg <= 9'h000;
    else
      lim_cnt_reg <= lim_cnt_next;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_ov_off; overvoltage_input [*5] |-> !gate_drive; endproperty
  a_ov_off: assert property (p_ov_off) else $error("gate on during overvoltage");
  property p_uv_off; !undervoltage_enable_input [*5] |-> !gate_drive; endproperty
  a_uv_off: assert property (p_uv_off) else $error("gate on during undervoltage");
  property p_good_low; !good_sense_input [*5] |-> !output_good_flag; endproperty
  a_good_low: assert property (p_good_low) else $error("good flag without sense");
  property p_reset_alert; $rose(resetn) |-> !alert_n; endproperty
  a_reset_alert: assert property (p_reset_alert) else $error("alert idle after reset");
  property p_trip_bound; lim_cnt_reg < 9'd300; endproperty
  a_trip_bound: assert property (p_trip_bound) else $error("limiting never timed out");
  property p_trip_early;
    $fell(gate_drive) && undervoltage_enable_input && !overvoltage_input
      |-> lim_cnt_reg >= 9'd200;
  endproperty
  a_trip_early: assert property (p_trip_early) else $error("gate off before timeout");
  property p_rd_good;
    reg_rd && reg_addr == 8'hE1 |=> reg_rdata[3] == $past(output_good_flag);
  endproperty
  a_rd_good: assert property (p_rd_good) else $error("good bit read wrong");
  property p_alert_ov; overvoltage_input [*6] |-> !alert_n; endproperty
  a_alert_ov: assert property (p_alert_ov) else $error("no alert on overvoltage");
  property p_sticky; !alert_n && !reg_wr |=> !alert_n; endproperty
  a_sticky: assert property (p_sticky) else $error("alert cleared by itself");
endmodule // hsfr_core_props
bind hsfr_core hsfr_core_props chk_u (
  .clk_sys(clk_sys), .resetn(resetn), .undervoltage_enable_input(undervoltage_enable_input),
  .overvoltage_input(overvoltage_input), .good_sense_input(good_sense_input),
  .power_limit_set_input(power_limit_set_input), .current_limit_input(current_limit_input),
  .retry_select_input(retry_select_input), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .gate_drive(gate_drive), .output_good_flag(output_good_flag), .alert_n(alert_n));

// ===== verif/hsfr_path_model.sv
// Behavioural pass transistor and load path facing the sequencer.
`timescale 1ns/1ns
module hsfr_path_model (
  input  wire clk_sys,
  input  wire resetn,
  input  wire gate_drive,
  input  wire ovl_pwr,
  input  wire ovl_cur,
  output reg  power_limit_set_input,
  output reg  current_limit_input,
  output wire good_sense_input
);
  reg [3:0] ramp_reg;
  // The output only counts as good after a short ramp with no overload.
  assign good_sense_input = (ramp_reg == 4'hF);
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ramp_reg              <= 4'h0;
      power_limit_set_input <= 1'b0;
      current_limit_input   <= 1'b0;
    end else begin
      power_limit_set_input <= gate_drive & ovl_pwr;
      current_limit_input   <= gate_drive & ovl_cur;
      if (!gate_drive || ovl_pwr || ovl_cur)
        ramp_reg <= 4'h0;
      else if (ramp_reg != 4'hF)
        ramp_reg <= ramp_reg + 4'h1;
    end
  end
endmodule // hsfr_path_model

// ===== verif/test_hsfr_core.sv
// Self-checking testbench of the hot-swap sequencer core.
`timescale 1ns/1ns
module test_hsfr_core;
  reg         clk_sys, resetn, uv, ov, rty, pw, pc, wrs, rds;
  reg  [7:0]  addr;
  reg  [15:0] wdata;
  reg  [15:0] rv;
  wire [15:0] rdata;
  wire        gate, good, alert_n, pl, cl, gs;
  integer     err_count, compares, wc;
  hsfr_path_model path_u (.clk_sys(clk_sys), .resetn(resetn), .gate_drive(gate),
    .ovl_pwr(pw), .ovl_cur(pc), .power_limit_set_input(pl),
    .current_limit_input(cl), .good_sense_input(gs));
  hsfr_core dut_u (.clk_sys(clk_sys), .resetn(resetn), .undervoltage_enable_input(uv),
    .overvoltage_input(ov), .good_sense_input(gs), .power_limit_set_input(pl),
    .current_limit_input(cl), .retry_select_input(rty), .reg_wr(wrs), .reg_rd(rds),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .gate_drive(gate),
    .output_good_flag(good), .alert_n(alert_n));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task wrap_up;
    begin
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Callers other than wg stand at a rising edge, where outputs still show the settled value.
  task ck(input string nm, input logic e, input logic g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[FAIL] %0s expected %b seen %b", nm, e, g);
      end
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk_sys);
      rds <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rds <= 1'b0;
      @(negedge clk_sys);
      rv = rdata;
      @(posedge clk_sys);
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge clk_sys);
      wrs <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk_sys);
      wrs <= 1'b0;
    end
  endtask
  task wg(input logic v, input integer mx);
    begin
      wc = 0;
      while (gate !== v && wc < mx) begin
        @(negedge clk_sys);
        wc = wc + 1;
      end
      ck("gate", v, gate);
      @(posedge clk_sys);
    end
  endtask
  task t_reset;
    begin
      ck("alert", 1'b0, alert_n);
      rd(8'h80);
      ck("preset", 1'b1, rv[4]);
      rd(8'h55);
      ck("unmapped", 1'b1, rv === 16'h0000);
      wr(8'h03, 16'h0000);
      tick(2);
      ck("alert", 1'b1, alert_n);
    end
  endtask
  task t_insert;
    begin
      wg(1'b1, 5000);
      ck("delay", 1'b1, wc > 3000);
      tick(30);
      ck("good", 1'b1, good);
      rd(8'hE1);
      ck("fs_good", 1'b1, rv[3]);
      rd(8'h79);
      ck("not_good", 1'b0, rv[11]);
    end
  endtask
  task t_ov;
    begin
      ov <= 1'b1;
      tick(6);
      ck("gate", 1'b0, gate);
      rd(8'h7C);
      ck("in_ov", 1'b1, rv[4]);
      ck("alert", 1'b0, alert_n);
      ov <= 1'b0;
      wg(1'b1, 20);
      rd(8'hE1);
      ck("fs_ov", 1'b1, rv[9]);
      wr(8'h03, 16'h0000);
      tick(2);
      ck("alert", 1'b1, alert_n);
    end
  endtask
  task t_uv;
    begin
      wr(8'hD8, 16'h0400);
      uv <= 1'b0;
      tick(6);
      ck("gate", 1'b0, gate);
      rd(8'h7C);
      ck("in_uv", 1'b1, rv[3]);
      ck("masked", 1'b1, alert_n);
      wr(8'hD8, 16'h0000);
      tick(2);
      ck("alert", 1'b0, alert_n);
      uv <= 1'b1;
      wg(1'b1, 5000);
      wr(8'h03, 16'h0000);
    end
  endtask
  task t_short;
    begin
      pw <= 1'b1;
      tick(150);
      pw <= 1'b0;
      tick(60);
      ck("gate", 1'b1, gate);
      pc <= 1'b1;
      tick(150);
      pc <= 1'b0;
      tick(60);
      ck("gate_cl", 1'b1, gate);
      rd(8'h7C);
      ck("in_ovl", 1'b0, rv[1]);
    end
  endtask
  task t_latch;
    begin
      rty <= 1'b1;
      pw <= 1'b1;
      wg(1'b0, 400);
      ck("timeout", 1'b1, wc >= 250 && wc <= 275);
      pw <= 1'b0;
      rd(8'h7C);
      ck("in_ovl", 1'b1, rv[1]);
      ck("alert", 1'b0, alert_n);
      tick(1000);
      ck("latched", 1'b0, gate);
      uv <= 1'b0;
      tick(10);
      uv <= 1'b1;
      tick(100);
      ck("early", 1'b0, gate);
      rd(8'hE1);
      ck("fs_lat", 1'b1, rv[7]);
      tick(6000);
      uv <= 1'b0;
      tick(10);
      uv <= 1'b1;
      wg(1'b1, 6000);
      rd(8'hE1);
      ck("fs_lat", 1'b0, rv[7]);
      wr(8'h03, 16'h0000);
    end
  endtask
  task t_auto;
    begin
      rty <= 1'b0;
      pw <= 1'b1;
      wg(1'b0, 400);
      wg(1'b1, 40000);
      ck("restart", 1'b1, wc > 30000 && wc < 32000);
      wg(1'b0, 400);
      pw <= 1'b0;
      wg(1'b1, 40000);
    end
  endtask
  task t_setup;
    begin
      wr(8'hD9, 16'h0020);
      rd(8'hD9);
      ck("setup", 1'b1, rv === 16'h0020);
      pc <= 1'b1;
      wg(1'b0, 400);
      pc <= 1'b0;
      tick(2000);
      ck("zero_rt", 1'b0, gate);
    end
  endtask
  initial begin
    err_count = 0;
    compares = 0;
    resetn = 1'b0;
    {uv, ov, rty, pw, pc, wrs, rds} = 7'b1000000;
    addr = 8'h00;
    wdata = 16'h0000;
    tick(6);
    resetn <= 1'b1;
    t_reset;
    t_insert;
    t_ov;
    t_uv;
    t_short;
    t_latch;
    t_auto;
    t_setup;
    wrap_up;
  end
  initial begin
    repeat (92000) @(posedge clk_sys);
    err_count = err_count + 1;
    wrap_up;
  end
endmodule // test_hsfr_core
